//--- logic/flash_status_config_regs.vh
// Constants of the status and configuration command block.
// Included by the block's single design file; holds definitions only.
`ifndef FLASH_STATUS_CONFIG_REGS_VH
`define FLASH_STATUS_CONFIG_REGS_VH

// Command opcodes
`define OP_WRITE_ENABLE     8'h06
`define OP_WRITE_DISABLE    8'h04
`define OP_WRITE_STATUS     8'h01
`define OP_WRITE_CONFIG     8'h11
`define OP_READ_CONFIG      8'h15
`define OP_ACTIVE_STATUS    8'h25
`define OP_ERASE_SUSPEND    8'h75
`define OP_PROGRAM_SUSPEND  8'hB0
`define OP_RESUME_A         8'h7A
`define OP_RESUME_B         8'h30

// Status word field positions
`define ST_ERASE_PAUSED     15
`define ST_PROTECT_COMP     14
`define ST_LOCK_HI          13
`define ST_LOCK_LO          11
`define ST_PROGRAM_PAUSED   10
`define ST_QUAD_ENABLE      9
`define ST_PROTECT_HI       8
`define ST_PROTECT_LO       7
`define ST_BLOCK_HI         6
`define ST_BLOCK_LO         2
`define ST_WRITE_LATCH      1
`define ST_BUSY             0

// Configuration field positions and reset value
`define CFG_DRIVE_HI        6
`define CFG_DRIVE_LO        5
`define CFG_RESET           8'h20
`define STATUS_RESET        16'h0000

// Frame lengths in serial clock rising edges
`define BITS_OPCODE         6'h08
`define BITS_ONE_BYTE       6'h10
`define BITS_TWO_BYTES      6'h18

// Self-timed register write cycle
`define STATUS_WRITE_TIME_NS 2000000
`define MCLK_PERIOD_NS       25

`endif

//--- logic/flash_status_config_access.v
// Status/configuration command interpreter of a serial NOR flash.
// Assumes the serial pins are synchronous to mclk and that mclk runs
// at least four times faster than the serial clock.
//
// Summary of operation
// - Suspend commands set erase/program paused flags
// - Resume or power cycle clears paused flags
// - Read config shifts config out, even busy
// - Config bits 6:5 select output drive
// - Active-status drives busy continuously while selected
// - Active-status output falls only, never rises
// - Chip select high ends active-status, floats output
// - Status write needs write enable latch set
// - Status write keeps bits 15,10,1,0
// - Status write ends after 8/16 bits only
// - Eight-bit status write clears complement,quad,protect-hi
// - Valid status write starts timed busy cycle
// - Hardware protection blocks status write entirely
// - Config write needs latch and exactly 8 bits
// - Config write runs timed busy cycle, clears latch
// - Busy at status bit 0, latch bit 1
// - Protect bits 01 with pin low locks status
`timescale 1ns/1ps
`include "flash_status_config_regs.vh"

module flash_status_config_access #(
  parameter WRITE_CYCLES =
    (`STATUS_WRITE_TIME_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS
) (
  // Clock and reset
  input  wire        mclk,
  input  wire        rst,
  // Serial pins
  input  wire        cs_n,
  input  wire        sclk,
  input  wire        si,
  input  wire        write_protect_n,
  output reg         so,
  output reg         so_oe,
  // Array engine busy, from program/erase logic
  input  wire        array_busy,
  // Register contents toward the core
  output reg  [15:0] status_word,
  output reg  [7:0]  output_config_reg,
  output reg  [1:0]  drive_strength
);

  // Read-output phases
  localparam OUT_IDLE   = 2'b00;
  localparam OUT_CONFIG = 2'b01;
  localparam OUT_ACTIVE = 2'b10;

  reg        sclk_q;
  reg        cs_q;
  reg  [5:0] bit_count;
  reg [23:0] shift_in;
  reg  [7:0] opcode;
  reg  [7:0] out_shift;
  reg  [1:0] out_phase;
  reg        write_busy;
  reg [31:0] write_timer;
  reg        pending_is_config;
  reg [15:0] pending_status;
  reg  [7:0] pending_config;
  reg [15:0] next_status;

  // Reset image of the config byte, sliced for the drive field
  localparam [7:0] CFG_RESET_VALUE = `CFG_RESET;

  wire sclk_rise          = sclk & ~sclk_q & ~cs_n;
  wire sclk_fall          = ~sclk & sclk_q & ~cs_n;
  wire cs_rise            = cs_n & ~cs_q;
  wire write_in_progress  = write_busy | array_busy;
  wire write_enable_latch = status_word[`ST_WRITE_LATCH];
  wire hw_lock            = (~status_word[`ST_PROTECT_HI] & status_word[`ST_PROTECT_LO]
                            & ~write_protect_n)
                            | status_word[`ST_PROTECT_HI];
  wire can_write          = write_enable_latch & ~write_in_progress;

  // Status value a write would commit; the low data byte lands first
  always @* begin
    next_status = status_word;
    if (bit_count == `BITS_ONE_BYTE) begin
      next_status[7:2]                = shift_in[7:2];
      next_status[`ST_PROTECT_COMP]   = 1'b0;
      next_status[`ST_QUAD_ENABLE]    = 1'b0;
      next_status[`ST_PROTECT_HI]     = 1'b0;
    end else begin
      next_status[7:2]                = shift_in[15:10];
      next_status[`ST_PROTECT_COMP]   = shift_in[6];
      // Lock bits are one-time: they can be set, never cleared
      next_status[`ST_LOCK_HI:`ST_LOCK_LO] =
        status_word[`ST_LOCK_HI:`ST_LOCK_LO] | shift_in[5:3];
      next_status[`ST_QUAD_ENABLE]    = shift_in[1];
      next_status[`ST_PROTECT_HI]     = shift_in[0];
    end
    // Paused flags and the two live bits never take written data
    next_status[`ST_ERASE_PAUSED]   = status_word[`ST_ERASE_PAUSED];
    next_status[`ST_PROGRAM_PAUSED] = status_word[`ST_PROGRAM_PAUSED];
    next_status[`ST_WRITE_LATCH]    = status_word[`ST_WRITE_LATCH];
    next_status[`ST_BUSY]           = status_word[`ST_BUSY];
  end

  // Edge history of the serial pins
  always @(posedge mclk) begin
    if (rst) begin
      sclk_q <= 1'b0;
      cs_q   <= 1'b1;
    end else begin
      sclk_q <= sclk;
      cs_q   <= cs_n;
    end
  end

  // Input shifter, bit counter and opcode capture
  always @(posedge mclk) begin
    if (rst) begin
      bit_count <= 6'h00;
      shift_in  <= 24'h000000;
      opcode    <= 8'h00;
    end else if (cs_n) begin
      bit_count <= 6'h00;
    end else if (sclk_rise) begin
      shift_in <= {shift_in[22:0], si};
      // Saturate so overlong frames never alias a valid length
      if (bit_count != 6'h3F)
        bit_count <= bit_count + 6'h01;
      if (bit_count == `BITS_OPCODE - 6'h01)
        opcode <= {shift_in[6:0], si};
    end
  end

  // Serial output: config read-out and active-status busy line
  always @(posedge mclk) begin
    if (rst) begin
      out_phase <= OUT_IDLE;
      out_shift <= 8'h00;
      so        <= 1'b0;
      so_oe     <= 1'b0;
    end else if (cs_n) begin
      out_phase <= OUT_IDLE;
      so_oe     <= 1'b0;
    end else begin
      case (out_phase)
        OUT_IDLE: begin
          if (sclk_rise && bit_count == `BITS_OPCODE - 6'h01) begin
            if ({shift_in[6:0], si} == `OP_READ_CONFIG) begin
              // Allowed at any time, busy or not
              out_phase <= OUT_CONFIG;
              out_shift <= output_config_reg;
            end else if ({shift_in[6:0], si} == `OP_ACTIVE_STATUS) begin
              // Later input bits are don't-care; no clocks are needed
              out_phase <= OUT_ACTIVE;
              so        <= write_in_progress;
              so_oe     <= 1'b1;
            end
          end
        end
        OUT_CONFIG: begin
          // New bit on each falling edge; the byte repeats while selected
          if (sclk_fall) begin
            so        <= out_shift[7];
            so_oe     <= 1'b1;
            out_shift <= {out_shift[6:0], out_shift[7]};
          end
        end
        OUT_ACTIVE: begin
          // AND keeps the line monotonic even if array busy re-rises
          so    <= so & write_in_progress;
          so_oe <= 1'b1;
        end
        default: begin
          out_phase <= OUT_IDLE;
          so_oe     <= 1'b0;
        end
      endcase
    end
  end

  // Command execution at chip-select release and the timed write cycle
  always @(posedge mclk) begin
    if (rst) begin
      // Reset stands for a power cycle: paused flags drop here
      status_word       <= `STATUS_RESET;
      output_config_reg <= `CFG_RESET;
      write_busy        <= 1'b0;
      write_timer       <= 32'h00000000;
      pending_is_config <= 1'b0;
      pending_status    <= `STATUS_RESET;
      pending_config    <= `CFG_RESET;
    end else begin
      status_word[`ST_BUSY] <= write_in_progress;
      if (write_busy) begin
        if (write_timer == 32'h00000001) begin
          write_busy <= 1'b0;
          status_word[`ST_WRITE_LATCH] <= 1'b0;
          if (pending_is_config) begin
            output_config_reg <= pending_config;
          end else begin
            // Paused flags skipped: a suspend during the cycle must survive
            status_word[14:11] <= pending_status[14:11];
            status_word[9:2]   <= pending_status[9:2];
          end
        end
        write_timer <= write_timer - 32'h00000001;
      end
      if (cs_rise) begin
        case (opcode)
          `OP_WRITE_ENABLE: begin
            if (bit_count == `BITS_OPCODE && !write_busy)
              status_word[`ST_WRITE_LATCH] <= 1'b1;
          end
          `OP_WRITE_DISABLE: begin
            if (bit_count == `BITS_OPCODE && !write_busy)
              status_word[`ST_WRITE_LATCH] <= 1'b0;
          end
          `OP_WRITE_STATUS: begin
            // Needs latch, no lock, and a whole-byte frame end
            if (can_write && !hw_lock &&
                (bit_count == `BITS_ONE_BYTE ||
                 bit_count == `BITS_TWO_BYTES)) begin
              write_busy        <= 1'b1;
              write_timer       <= WRITE_CYCLES;
              pending_is_config <= 1'b0;
              pending_status    <= next_status;
            end
          end
          `OP_WRITE_CONFIG: begin
            if (can_write && bit_count == `BITS_ONE_BYTE) begin
              write_busy        <= 1'b1;
              write_timer       <= WRITE_CYCLES;
              pending_is_config <= 1'b1;
              // Reserved bits are not stored and read as zero
              pending_config    <= shift_in[7:0] & `CFG_RESET | shift_in[7:0] & 8'h40;
            end
          end
          `OP_ERASE_SUSPEND: begin
            if (bit_count == `BITS_OPCODE)
              status_word[`ST_ERASE_PAUSED] <= 1'b1;
          end
          `OP_PROGRAM_SUSPEND: begin
            if (bit_count == `BITS_OPCODE)
              status_word[`ST_PROGRAM_PAUSED] <= 1'b1;
          end
          `OP_RESUME_A, `OP_RESUME_B: begin
            if (bit_count == `BITS_OPCODE) begin
              status_word[`ST_ERASE_PAUSED]   <= 1'b0;
              status_word[`ST_PROGRAM_PAUSED] <= 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Drive strength code: 00=75% 01=100% 10=150% 11=50%
  always @(posedge mclk) begin
    if (rst)
      drive_strength <= CFG_RESET_VALUE[`CFG_DRIVE_HI:`CFG_DRIVE_LO];
    else
      drive_strength <= output_config_reg[`CFG_DRIVE_HI:`CFG_DRIVE_LO];
  end

endmodule

//--- tb/flash_status_config_props.sv
// Assertions on the status/config block's ports.
// Bound into every instance of the block below; one clock, sync reset.
`timescale 1ns/1ps
module flash_status_config_props (
  // Clock and reset
  input wire        mclk,
  input wire        rst,
  // Serial pins
  input wire        cs_n,
  input wire        sclk,
  input wire        si,
  input wire        write_protect_n,
  input wire        so,
  input wire        so_oe,
  // Core side
  input wire        array_busy,
  input wire [15:0] status_word,
  input wire [7:0]  output_config_reg,
  input wire [1:0]  drive_strength
);
  reg       sclk_q;
  reg [7:0] op;
  reg [5:0] cnt;
  // Frame decode: active-status wait once its opcode is in
  wire      active_wait = !cs_n && cnt >= 6'h08 && op == 8'h25;
  wire      lock = status_word[8] || (status_word[7] && !write_protect_n);
  wire      idle = status_word[1] && !status_word[0];
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Opcode and rise count; saturates so a long frame never wraps
  always @(posedge mclk) begin
    sclk_q <= sclk;
    if (rst || cs_n)
      cnt <= 6'h00;
    else if (sclk && !sclk_q && cnt != 6'h3F) begin
      cnt <= cnt + 6'h01;
      op  <= cnt < 6'h08 ? {op[6:0], si} : op;
    end
  end
  a_cfg_reserved_zero: assert property (
    {output_config_reg[7], output_config_reg[4:0]} == 6'h00) else $error("config reserved set");
  a_drive_from_cfg: assert property (
    $stable(output_config_reg) |-> drive_strength == output_config_reg[6:5])
    else $error("drive strength not from config");
  a_oe_off_deselect: assert property (cs_n |=> !so_oe)
    else $error("output driven while deselected");
  a_wait_no_rise: assert property (
    active_wait && $past(so_oe) && !$past(so) |-> !so) else $error("active status output rose");
  a_wait_drives_out: assert property (active_wait && $past(active_wait, 2) |-> so_oe)
    else $error("active status output not driven");
  // Falls with busy one cycle behind, and once low stays low
  a_wait_tracks_busy: assert property (
    active_wait && $past(active_wait) && $past(so_oe)
    |-> so == ($past(so) && status_word[0])) else $error("active status output not busy");
  a_cfg_write_busy: assert property (
    $rose(cs_n) && op == 8'h11 && cnt == 6'h10 && idle |-> ##[1:4] status_word[0])
    else $error("config write did not start busy");
  a_sts_write_busy: assert property (
    $rose(cs_n) && op == 8'h01 && (cnt == 6'h10 || cnt == 6'h18) && idle && !lock
    |-> ##[1:4] status_word[0]) else $error("status write did not start busy");
  a_cfg_change_wel: assert property (
    $changed(output_config_reg) |-> $past(status_word[1]) && !status_word[1])
    else $error("config changed without latch");
  a_paused_on_edge: assert property (
    $changed({status_word[15], status_word[10]}) |-> cs_n) else $error("paused flag mid-frame");
  c_wait_ready: cover property (active_wait && $fell(so));
  c_cfg_commit: cover property ($changed(output_config_reg));
  c_sts_start: cover property ($rose(status_word[0]) && !array_busy);
endmodule
bind flash_status_config_access flash_status_config_props i_flash_status_config_props (
  .mclk(mclk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .si(si),
  .write_protect_n(write_protect_n), .so(so), .so_oe(so_oe), .array_busy(array_busy),
  .status_word(status_word), .output_config_reg(output_config_reg),
  .drive_strength(drive_strength));

//--- tb/spi_host_model.sv
// SPI host controller model, mode 0, driving the flash serial pins.
// Assumes mclk is the bench clock; pins change at its falling edge.
`timescale 1ns/1ps
module spi_host_model (
  // Clock
  input  wire  mclk,
  // Serial pins
  input  wire  so,
  input  wire  so_oe,
  output logic cs_n,
  output logic sclk,
  output logic si
);
  // Idle pins at time zero
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si   = 1'b0;
  end
  // Ends a frame; the released input shows junk, not a held value
  task automatic release_cs;
    @(negedge mclk);
    cs_n = 1'b1;
    si   = ~si;
    repeat (3) @(negedge mclk);
  endtask
  // One frame of n bits, MSB first; so taken just before each rise
  task automatic xfer(input logic [23:0] d, input int n, input bit hold,
                      output logic [7:0] rd);
    int i;
    rd = 8'h00;
    @(negedge mclk);
    cs_n = 1'b0;
    for (i = 0; i < n; i++) begin
      @(negedge mclk);
      sclk = 1'b0;
      si   = d[23-i];
      repeat (2) @(negedge mclk);
      rd   = {rd[6:0], so_oe ? so : ~so}; // Undriven line reads inverted
      sclk = 1'b1;
      repeat (2) @(negedge mclk);
    end
    @(negedge mclk);
    sclk = 1'b0;
    if (!hold)
      release_cs();
    else
      si = ~si;
  endtask
endmodule

//--- tb/flash_status_config_access_tb.sv
// Testbench of the status/config block, driven through the host model.
// Assumes a shortened timed write cycle so the run stays brief.
`timescale 1ns/1ps
module flash_status_config_access_tb;
  logic        mclk;
  logic        rst;
  logic        write_protect_n;
  logic        array_busy;
  wire         cs_n, sclk, si, so, so_oe;
  wire  [15:0] status_word;
  wire  [7:0]  output_config_reg;
  wire  [1:0]  drive_strength;
  logic [7:0]  rd;
  int          mismatches;
  int          compares;
  int          k;
  flash_status_config_access #(.WRITE_CYCLES(200)) i_flash_status_config_access (
    .mclk(mclk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .si(si),
    .write_protect_n(write_protect_n), .so(so), .so_oe(so_oe), .array_busy(array_busy),
    .status_word(status_word), .output_config_reg(output_config_reg),
    .drive_strength(drive_strength));
  spi_host_model i_spi_host_model (.mclk(mclk), .so(so), .so_oe(so_oe), .cs_n(cs_n),
    .sclk(sclk), .si(si));
  // 40 MHz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cmd(input logic [23:0] d, input int n);
    i_spi_host_model.xfer(d, n, 1'b0, rd);
  endtask
  // Polls busy, as a host should before its next command
  task automatic wait_idle;
    int i;
    for (i = 0; i < 2000 && status_word[0] !== 1'b0; i++)
      @(negedge mclk);
    check("busy clears", status_word[0], 16'h0000);
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Watchdog: about six times the expected run
  initial begin
    #500000;
    mismatches++;
    stop_test();
  end
  initial begin
    mismatches = 0;
    compares = 0;
    rst = 1'b1;
    write_protect_n = 1'b1;
    array_busy = 1'b0;
    repeat (8) @(negedge mclk);
    rst = 1'b0;
    check("cfg reset", {drive_strength, so_oe, 5'h00, output_config_reg}, 16'h4020);
    // Read back and wait while the array engine is busy
    array_busy = 1'b1;
    i_spi_host_model.xfer(24'h150000, 16, 1'b0, rd);
    check("cfg read busy", rd, 16'h0020);
    i_spi_host_model.xfer(24'h250000, 8, 1'b1, rd);
    repeat (4) @(negedge mclk);
    check("wait busy", {status_word[0], so_oe, so}, 16'h0007);
    array_busy = 1'b0;
    repeat (4) @(negedge mclk);
    check("wait ready", {so_oe, so}, 16'h0002);
    // A busy pulse after the fall must not lift the line again
    array_busy = 1'b1;
    repeat (4) @(negedge mclk);
    check("wait stays low", {status_word[0], so_oe, so}, 16'h0006);
    array_busy = 1'b0;
    i_spi_host_model.release_cs();
    check("wait float", so_oe, 16'h0000);
    // Config write refused: no latch, then one bit short
    cmd(24'h114000, 16);
    check("cfg no latch", {status_word[7:0], output_config_reg}, 16'h0020);
    cmd(24'h060000, 8);
    cmd(24'h114000, 15);
    check("cfg short", {status_word[7:0], output_config_reg}, 16'h0220);
    cmd(24'h040000, 8);
    check("latch off", status_word[1], 16'h0000);
    // Every drive code written, committed and read back
    for (k = 0; k < 4; k++) begin
      cmd(24'h060000, 8);
      // Reserved bits sent as ones; only the drive field may stick
      cmd({8'h11, 1'b1, k[1:0], 5'h1F, 8'h00}, 16);
      check("cfg busy", status_word[1:0], 16'h0003);
      wait_idle();
      check("cfg done", {status_word[1:0], 6'h00, drive_strength}, {14'h0, k[1:0]});
      i_spi_host_model.xfer(24'h150000, 16, 1'b0, rd);
      check("cfg read", rd, {9'h000, k[1:0], 5'h00});
    end
    // Status writes: no latch, two bytes, one byte, locked, bad length
    cmd(24'h017FFE, 24);
    check("sts no latch", status_word, 16'h0000);
    cmd(24'h060000, 8);
    cmd(24'h017FFE, 24);
    check("sts busy", status_word[1:0], 16'h0003);
    wait_idle();
    check("sts two", status_word, 16'h7A7C);
    cmd(24'h060000, 8);
    cmd(24'h019C00, 16);
    wait_idle();
    check("sts one", status_word, 16'h389C);
    write_protect_n = 1'b0;
    cmd(24'h060000, 8);
    cmd(24'h010000, 16);
    check("sts locked", status_word, 16'h389E);
    write_protect_n = 1'b1;
    cmd(24'h01FF00, 9);
    check("sts nine", status_word, 16'h389E);
    // Suspend, resume and power cycle
    cmd(24'h750000, 8);
    cmd(24'hB00000, 8);
    check("paused", {status_word[15], status_word[10]}, 16'h0003);
    cmd(24'h7A0000, 8);
    check("resume", {status_word[15], status_word[10]}, 16'h0000);
    cmd(24'hB00000, 8);
    cmd(24'h300000, 8);
    check("resume alt", status_word[10], 16'h0000);
    cmd(24'h750000, 8);
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    check("power cycle", status_word, 16'h0000);
    stop_test();
  end
endmodule
